//--- bsot_consts.vh
`ifndef BSOT_CONSTS_VH
`define BSOT_CONSTS_VH
// ----------------------------------------
// register widths
// ----------------------------------------
`define BSOT_IR_W 8
`define BSOT_BSR_W 18
`define BSOT_BCR_W 2
// ----------------------------------------
// reset and capture values
// ----------------------------------------
`define BSOT_IR_RST 8'hFF
`define BSOT_IR_CAPT 8'h81
`define BSOT_BCR_RST 2'h2
// ----------------------------------------
// boundary cell positions
// ----------------------------------------
`define BSOT_CELL_OE 0
`define BSOT_CELL_DIR 1
`define BSOT_CELL_A 2
`define BSOT_CELL_B 10
// ----------------------------------------
// opcodes
// ----------------------------------------
`define BSOT_OP_EXTEST 8'h00
`define BSOT_OP_SAMPLE 8'h82
`define BSOT_OP_INTEST 8'h03
`define BSOT_OP_HIGHZ 8'h06
`define BSOT_OP_CLAMP 8'h07
`define BSOT_OP_RUNT 8'h09
`define BSOT_OP_BCRSEL 8'h0A
`define BSOT_OP_BYPASS 8'hFF
// ----------------------------------------
// boundary-control operations
// ----------------------------------------
`define BSOT_BC_TOGGLE 2'h0
`define BSOT_BC_OUTPUT_PATTERN_GENERATION 2'h1
`define BSOT_BC_INPUT_SIGNATURE_COMPACTION 2'h2
`endif

//--- bsot_transceiver.v
// How it works
// - oe_n low: dir picks direction; else isolate
// - tap activity never disturbs normal data path
// - test mode drives pins from boundary cells
// - sample on tck rise, outputs change on fall
// - only sampled tms advances the tap states
// - tdi to tdo through ir or data register
// - instruction register is eight bits
// - boundary 18, control 2, bypass 1 bit
// - double-high tms level resets test logic
// - sample possible in normal mode; self-test is a test mode
// - standard, signature, pattern and toggle instructions
// - reset loads ir all ones, control 10
// - ir capture loads 10000001
// - tms high five clocks reaches reset state
`timescale 1ns/1ps
`include "bsot_consts.vh"
module bsot_transceiver (
  input wire clk_in,
  input wire rst_n_in,
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  input wire tms_double_high_in,
  input wire oe_n_in,
  input wire dir_in,
  input wire [7:0] a_side_lanes_in,
  input wire [7:0] b_side_lanes_in,
  output reg [7:0] a_side_lanes_out,
  output reg a_side_lanes_oe_n_out,
  output reg [7:0] b_side_lanes_out,
  output reg b_side_lanes_oe_n_out,
  output reg tdo_out,
  output reg tdo_oe_n_out
);
  localparam [3:0] TLR = 4'h0;
  localparam [3:0] RTI = 4'h1;
  localparam [3:0] SEL_DR = 4'h2;
  localparam [3:0] CAP_DR = 4'h3;
  localparam [3:0] SH_DR = 4'h4;
  localparam [3:0] EX1_DR = 4'h5;
  localparam [3:0] PAU_DR = 4'h6;
  localparam [3:0] EX2_DR = 4'h7;
  localparam [3:0] UPD_DR = 4'h8;
  localparam [3:0] SEL_IR = 4'h9;
  localparam [3:0] CAP_IR = 4'hA;
  localparam [3:0] SH_IR = 4'hB;
  localparam [3:0] EX1_IR = 4'hC;
  localparam [3:0] PAU_IR = 4'hD;
  localparam [3:0] EX2_IR = 4'hE;
  localparam [3:0] UPD_IR = 4'hF;
  localparam NS = 22;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [NS-1:0] raw;
  reg [NS-1:0] s1;
  reg [NS-1:0] s2;
  reg tck_d;
  assign raw = {tck_in, tms_in, tdi_in, tms_double_high_in, oe_n_in, dir_in,
                a_side_lanes_in, b_side_lanes_in};
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1 <= {NS{1'b1}};
      s2 <= {NS{1'b1}};
      tck_d <= 1'b1;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      tck_d <= s2[21];
    end
  end
  wire tck_s = s2[21];
  wire tms_s = s2[20];
  wire tdi_s = s2[19];
  wire dh_s = s2[18];
  wire oe_n_s = s2[17];
  wire dir_s = s2[16];
  wire [7:0] a_s = s2[15:8];
  wire [7:0] b_s = s2[7:0];
  wire rise = tck_s & ~tck_d;
  wire fall = ~tck_s & tck_d;

  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  reg [3:0] state;
  reg [3:0] next_state;
  always @*
  begin
    next_state = state;
    case (state)
      TLR: next_state = tms_s ? TLR : RTI;
      RTI: next_state = tms_s ? SEL_DR : RTI;
      SEL_DR: next_state = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: next_state = tms_s ? EX1_DR : SH_DR;
      SH_DR: next_state = tms_s ? EX1_DR : SH_DR;
      EX1_DR: next_state = tms_s ? UPD_DR : PAU_DR;
      PAU_DR: next_state = tms_s ? EX2_DR : PAU_DR;
      EX2_DR: next_state = tms_s ? UPD_DR : SH_DR;
      UPD_DR: next_state = tms_s ? SEL_DR : RTI;
      SEL_IR: next_state = tms_s ? TLR : CAP_IR;
      CAP_IR: next_state = tms_s ? EX1_IR : SH_IR;
      SH_IR: next_state = tms_s ? EX1_IR : SH_IR;
      EX1_IR: next_state = tms_s ? UPD_IR : PAU_IR;
      PAU_IR: next_state = tms_s ? EX2_IR : PAU_IR;
      EX2_IR: next_state = tms_s ? UPD_IR : SH_IR;
      default: next_state = tms_s ? SEL_DR : RTI;
    endcase
  end

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  reg [7:0] ir;
  reg [7:0] ir_sh;
  function is_test;
    input [7:0] op;
    begin
      is_test = (op == `BSOT_OP_EXTEST) || (op == `BSOT_OP_INTEST) ||
                (op == `BSOT_OP_HIGHZ) || (op == `BSOT_OP_CLAMP) ||
                (op == `BSOT_OP_RUNT);
    end
  endfunction
  wire test_mode = is_test(ir);
  wire sel_bsr = (ir == `BSOT_OP_EXTEST) || (ir == `BSOT_OP_SAMPLE) ||
                 (ir == `BSOT_OP_INTEST);
  wire sel_bcr = (ir == `BSOT_OP_BCRSEL);

  // ----------------------------------------
  // signature and pattern step
  // ----------------------------------------
  function [15:0] lfsr;
    input [15:0] v;
    begin
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    end
  endfunction

  // ----------------------------------------
  // test registers
  // ----------------------------------------
  reg [17:0] bsr_sh;
  reg [17:0] bsr_upd;
  reg [1:0] bcr_sh;
  reg [1:0] bcr;
  reg byp;
  wire [17:0] pins = {b_s, a_s, dir_s, oe_n_s};
  wire [15:0] outs = bsr_upd[17:2];
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= TLR;
      ir <= `BSOT_IR_RST;
      ir_sh <= `BSOT_IR_RST;
      bsr_sh <= 18'h0_0000;
      bsr_upd <= 18'h0_0000;
      bcr_sh <= `BSOT_BCR_RST;
      bcr <= `BSOT_BCR_RST;
      byp <= 1'b0;
      tdo_out <= 1'b1;
      tdo_oe_n_out <= 1'b1;
    end
    else if (dh_s)
    begin
      state <= TLR;
      ir <= `BSOT_IR_RST;
      bcr <= `BSOT_BCR_RST;
      tdo_oe_n_out <= 1'b1;
    end
    else
    begin
      if (rise)
      begin
        state <= next_state;
        case (state)
          CAP_IR: ir_sh <= `BSOT_IR_CAPT;
          SH_IR: ir_sh <= {tdi_s, ir_sh[7:1]};
          CAP_DR:
          begin
            if (sel_bsr)
              bsr_sh <= pins;
            if (sel_bcr)
              bcr_sh <= bcr;
            byp <= 1'b0;
          end
          SH_DR:
          begin
            if (sel_bsr)
              bsr_sh <= {tdi_s, bsr_sh[17:1]};
            else if (sel_bcr)
              bcr_sh <= {tdi_s, bcr_sh[1]};
            else
              byp <= tdi_s;
          end
          default: byp <= byp;
        endcase
      end
      if (fall)
      begin
        if (state == TLR)
        begin
          ir <= `BSOT_IR_RST;
          bcr <= `BSOT_BCR_RST;
        end
        if (state == UPD_IR)
          ir <= ir_sh;
        if (state == UPD_DR && sel_bsr)
          bsr_upd <= bsr_sh;
        if (state == UPD_DR && sel_bcr)
          bcr <= bcr_sh;
        if (state == RTI && ir == `BSOT_OP_RUNT)
        begin
          case (bcr)
            `BSOT_BC_OUTPUT_PATTERN_GENERATION: bsr_upd[17:2] <= lfsr(outs);
            `BSOT_BC_TOGGLE: bsr_upd[17:2] <= ~outs;
            default: bsr_upd[17:2] <= lfsr(outs) ^ {b_s, a_s};
          endcase
        end
        if (state == SH_IR)
        begin
          tdo_out <= ir_sh[0];
          tdo_oe_n_out <= 1'b0;
        end
        else if (state == SH_DR)
        begin
          tdo_out <= sel_bsr ? bsr_sh[0] : (sel_bcr ? bcr_sh[0] : byp);
          tdo_oe_n_out <= 1'b0;
        end
        else
          tdo_oe_n_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // lane drivers
  // ----------------------------------------
  reg ctl_oe_n;
  reg ctl_dir;
  always @*
  begin
    ctl_oe_n = test_mode ? bsr_upd[`BSOT_CELL_OE] : oe_n_s;
    ctl_dir = test_mode ? bsr_upd[`BSOT_CELL_DIR] : dir_s;
  end
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      a_side_lanes_out <= 8'h00;
      b_side_lanes_out <= 8'h00;
      a_side_lanes_oe_n_out <= 1'b1;
      b_side_lanes_oe_n_out <= 1'b1;
    end
    else if (test_mode)
    begin
      a_side_lanes_out <= bsr_upd[9:2];
      b_side_lanes_out <= bsr_upd[17:10];
      a_side_lanes_oe_n_out <= (ir == `BSOT_OP_HIGHZ) | ctl_oe_n | ctl_dir;
      b_side_lanes_oe_n_out <= (ir == `BSOT_OP_HIGHZ) | ctl_oe_n | ~ctl_dir;
    end
    else
    begin
      a_side_lanes_out <= b_s;
      b_side_lanes_out <= a_s;
      a_side_lanes_oe_n_out <= ctl_oe_n | ctl_dir;
      b_side_lanes_oe_n_out <= ctl_oe_n | ~ctl_dir;
    end
  end
endmodule // bsot_transceiver

//--- bsot_transceiver_assertions.sv
`timescale 1ns/1ps
module bsot_transceiver_chk (
  input wire clk_in,
  input wire rst_n_in,
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  input wire tms_double_high_in,
  input wire oe_n_in,
  input wire dir_in,
  input wire [7:0] a_side_lanes_in,
  input wire [7:0] b_side_lanes_in,
  input wire [7:0] a_side_lanes_out,
  input wire a_side_lanes_oe_n_out,
  input wire [7:0] b_side_lanes_out,
  input wire b_side_lanes_oe_n_out,
  input wire tdo_out,
  input wire tdo_oe_n_out
);
  wire aoe = a_side_lanes_oe_n_out;
  wire boe = b_side_lanes_oe_n_out;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // pins held while test logic is forced to reset
  sequence still;
    tms_double_high_in && $stable({oe_n_in, dir_in, a_side_lanes_in, b_side_lanes_in});
  endsequence
  chk_iso_both: assert property (still[*6] ##0 oe_n_in |-> aoe && boe)
    else $error("lanes not isolated");
  chk_b_to_a: assert property (still[*6] ##0 (!oe_n_in && !dir_in) |->
    !aoe && boe && a_side_lanes_out == b_side_lanes_in) else $error("b to a wrong");
  chk_a_to_b: assert property (still[*6] ##0 (!oe_n_in && dir_in) |->
    aoe && !boe && b_side_lanes_out == a_side_lanes_in) else $error("a to b wrong");
  chk_tdo_release: assert property (tms_double_high_in[*4] |-> tdo_oe_n_out)
    else $error("tdo driven in reset");
  chk_tdo_fall: assert property ($fell(tdo_oe_n_out) |-> !tck_in && !$past(tck_in, 2))
    else $error("tdo enabled off fall");
  chk_tap_still: assert property ((tck_in && !tms_double_high_in)[*4] |->
    $stable(tdo_out) && $stable(tdo_oe_n_out)) else $error("tdo moved");
  chk_one_driver: assert property (aoe || boe)
    else $error("both sides driven");
  chk_reset_idle: assert property ($rose(rst_n_in) |-> aoe && boe && tdo_oe_n_out)
    else $error("outputs not idle");
endmodule // bsot_transceiver_chk
bind bsot_transceiver bsot_transceiver_chk u_chk (.clk_in, .rst_n_in, .tck_in, .tms_in,
  .tdi_in, .tms_double_high_in, .oe_n_in, .dir_in, .a_side_lanes_in, .b_side_lanes_in,
  .a_side_lanes_out, .a_side_lanes_oe_n_out, .b_side_lanes_out, .b_side_lanes_oe_n_out,
  .tdo_out, .tdo_oe_n_out);

//--- bsot_tap_host.sv
`timescale 1ns/1ps
module bsot_tap_host (
  input wire clk_in,
  input wire tdo_in,
  output logic tck_out = 1'b0,
  output logic tms_out = 1'b1,
  output logic tdi_out = 1'b1
);
  // one tck period of 80 ns, tck idle low
  task step(input logic t, input logic d, output logic q);
  begin
    @(negedge clk_in);
    tms_out = t;
    tdi_out = d;
    repeat (3) @(negedge clk_in);
    tck_out = 1'b1;
    q = tdo_in;
    repeat (4) @(negedge clk_in);
    tck_out = 1'b0;
  end
  endtask
  task tap_reset;
    logic q;
  begin
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  end
  endtask
  // from idle: scan ir or dr, back to idle
  task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    int i;
  begin
    dout = 32'h0000_0000;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  end
  endtask
endmodule // bsot_tap_host

//--- test_boundary_scan_octal_transceiver.sv
`timescale 1ns/1ps
`include "bsot_consts.vh"
module test_boundary_scan_octal_transceiver;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tms_double_high_in = 1'b0;
  logic oe_n_in = 1'b1;
  logic dir_in = 1'b0;
  logic [7:0] a_side_lanes_in = 8'h00;
  logic [7:0] b_side_lanes_in = 8'h00;
  wire tck_in, tms_in, tdi_in, tdo_out, tdo_oe_n_out, a_oe_n, b_oe_n;
  wire [7:0] a_o, b_o;
  wire tdo_line = tdo_oe_n_out ? 1'b1 : tdo_out;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] d;
  logic [7:0] pat;
  logic [15:0] sig;
  logic q;
  int k;
  bsot_transceiver DUT (.clk_in, .rst_n_in, .tck_in, .tms_in, .tdi_in, .tms_double_high_in,
    .oe_n_in, .dir_in, .a_side_lanes_in, .b_side_lanes_in, .a_side_lanes_out(a_o),
    .a_side_lanes_oe_n_out(a_oe_n), .b_side_lanes_out(b_o), .b_side_lanes_oe_n_out(b_oe_n),
    .tdo_out, .tdo_oe_n_out);
  bsot_tap_host u_host (.clk_in, .tdo_in(tdo_line), .tck_out(tck_in), .tms_out(tms_in),
    .tdi_out(tdi_in));
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  task summarize;
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk_word(input string nm, input logic [17:0] e, input logic [17:0] s);
  begin
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
  begin
    chk_word(nm, {10'h000, e}, {10'h000, s});
  end
  endtask
  // model of the normal function table
  task chk_lanes;
    logic [1:0] en;
  begin
    en = oe_n_in ? 2'b11 : (dir_in ? 2'b10 : 2'b01);
    chk_byte("enables", {6'h00, en}, {6'h00, a_oe_n, b_oe_n});
    if (!en[1]) chk_byte("a_lanes", b_side_lanes_in, a_o);
    if (!en[0]) chk_byte("b_lanes", a_side_lanes_in, b_o);
  end
  endtask
  task set_pins(input int c);
  begin
    @(negedge clk_in);
    a_side_lanes_in = 8'($urandom);
    b_side_lanes_in = 8'($urandom);
    oe_n_in = (c % 3 == 2);
    dir_in = c[0];
    repeat (10) @(negedge clk_in);
  end
  endtask
  initial
  begin
    void'($urandom(23));
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge clk_in);
    for (k = 0; k < 6; k++)
    begin
      set_pins(k);
      chk_lanes();
    end
    u_host.tap_reset();
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_SAMPLE}, d);
    chk_byte("ir_capture", `BSOT_IR_CAPT, d[7:0]);
    set_pins(2);
    pat = 8'($urandom);
    u_host.scan(1'b0, 18, {14'h0000, pat, pat, 2'b10}, d);
    chk_word("dr_sample", {b_side_lanes_in, a_side_lanes_in, dir_in, oe_n_in}, d[17:0]);
    chk_lanes();
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_EXTEST}, d);
    repeat (4) @(negedge clk_in);
    chk_byte("b_test", pat, b_o);
    chk_byte("en_test", 8'h02, {6'h00, a_oe_n, b_oe_n});
    u_host.tap_reset();
    repeat (4) @(negedge clk_in);
    chk_lanes();
    u_host.scan(1'b0, 4, 32'h0000_000d, d);
    chk_byte("bypass", 8'h0a, d[7:0]);
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_EXTEST}, d);
    tms_double_high_in = 1'b1;
    for (k = 0; k < 6; k++)
    begin
      set_pins(k);
      chk_lanes();
    end
    tms_double_high_in = 1'b0;
    u_host.tap_reset();
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_BCRSEL}, d);
    chk_byte("ir_capture", `BSOT_IR_CAPT, d[7:0]);
    u_host.scan(1'b0, 2, {30'h0000_0000, `BSOT_BC_TOGGLE}, d);
    chk_byte("control_reset", {6'h00, `BSOT_BCR_RST}, d[7:0]);
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_HIGHZ}, d);
    repeat (4) @(negedge clk_in);
    chk_byte("en_highz", 8'h03, {6'h00, a_oe_n, b_oe_n});
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_RUNT}, d);
    repeat (4) @(negedge clk_in);
    chk_byte("b_toggle", ~pat, b_o);
    u_host.step(1'b0, 1'b1, q);
    repeat (4) @(negedge clk_in);
    chk_byte("b_toggle", pat, b_o);
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_CLAMP}, d);
    repeat (4) @(negedge clk_in);
    chk_byte("b_clamp", pat, b_o);
    u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_INTEST}, d);
    u_host.scan(1'b0, 18, {14'h0000, ~pat, ~pat, 2'b00}, d);
    chk_word("dr_intest", {b_side_lanes_in, a_side_lanes_in, dir_in, oe_n_in}, d[17:0]);
    repeat (4) @(negedge clk_in);
    chk_byte("a_intest", ~pat, a_o);
    chk_byte("en_intest", 8'h01, {6'h00, a_oe_n, b_oe_n});
    sig = {~pat, ~pat};
    for (k = 0; k < 2; k++)
    begin
      u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_BCRSEL}, d);
      u_host.scan(1'b0, 2, 32'(k + 1), d);
      chk_byte("control", 8'(k), d[7:0]);
      u_host.scan(1'b1, 8, {24'h00_0000, `BSOT_OP_RUNT}, d);
      repeat (4) @(negedge clk_in);
      sig = {sig[14:0], sig[15] ^ sig[13] ^ sig[12] ^ sig[10]};
      if (k == 1) sig = sig ^ {b_side_lanes_in, a_side_lanes_in};
      chk_byte("a_runt", sig[7:0], a_o);
    end
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
endmodule // test_boundary_scan_octal_transceiver
